/* rtl/chg_regs.sv */
// charge current and input voltage control registers with serial slave
// assumes open-drain bus resolved outside; control pulses on sys_clk
`timescale 1ns/1ps
module chg_regs #(
    parameter logic [6:0] SLAVE_ADDR = chg_pkg::SLAVE_ADDR
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       regResetReq,
    input  wire logic       watchdogExpired,
    input  wire logic       sourceDetectDone,
    output logic            hostWrite,
    output logic            inputHighzEnable,
    output logic            limitPinEnable,
    output logic [5:0]      fastChargeCurrentCode,
    output logic            inputVlimitPluginRestore,
    output logic            batteryDischargeLoadEnable,
    output logic            outOfAudioDisable,
    output logic [4:0]      inputVoltageLimitCode
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    chg_pkg::chg_bus_state_t state_q;
    logic       sclS;
    logic       sdaS;
    logic       sclPrev_q;
    logic       sdaPrev_q;
    logic       busStart;
    logic       busStop;
    logic       sclRise;
    logic       sclFall;
    logic [7:0] shift_q;
    logic [3:0] bitCnt_q;
    logic       ackPhase_q;
    logic       masterNack_q;
    logic [7:0] ptr_q;
    logic [7:0] txByte_q;
    logic       wrStb_q;
    logic [7:0] wrAddr_q;
    logic [7:0] wrData_q;
    logic [7:0] curr_q;
    logic [7:0] volt_q;
    logic [5:0] fccClamped;
    logic [4:0] vlimClamped;

    // ---------------------------------------------------------------
    // pin synchronisers and bus events
    // ---------------------------------------------------------------
    chg_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pinIn   (sclIn),
        .pinOut  (sclS)
    );

    chg_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pinIn   (sdaIn),
        .pinOut  (sdaS)
    );

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    assign busStart = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign busStop  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
    assign sclRise  = sclS & ~sclPrev_q;
    assign sclFall  = ~sclS & sclPrev_q;

    function automatic logic regValid(input logic [7:0] a);
        regValid = (a == chg_pkg::CURR_OFF) || (a == chg_pkg::VOLT_OFF);
    endfunction

    // unmapped addresses read as 0x00: read auto-increment can carry the pointer past the map
    function automatic logic [7:0] regRead(input logic [7:0] a);
        if (a == chg_pkg::CURR_OFF)
            regRead = curr_q;
        else if (a == chg_pkg::VOLT_OFF)
            regRead = volt_q;
        else
            regRead = 8'h00;
    endfunction

    // ---------------------------------------------------------------
    // serial slave
    // ---------------------------------------------------------------
    // open drain: the line is only ever pulled low
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            sdaOut <= 1'b0;
        else
            sdaOut <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q      <= chg_pkg::ST_IDLE;
            shift_q      <= 8'h00;
            bitCnt_q     <= 4'h0;
            ackPhase_q   <= 1'b0;
            masterNack_q <= 1'b0;
            ptr_q        <= 8'h00;
            txByte_q     <= 8'h00;
            sdaOe        <= 1'b0;
            wrStb_q      <= 1'b0;
            wrAddr_q     <= 8'h00;
            wrData_q     <= 8'h00;
        end
        else
        begin
            wrStb_q <= 1'b0;
            if (busStop)
            begin
                state_q    <= chg_pkg::ST_IDLE;
                ackPhase_q <= 1'b0;
                sdaOe      <= 1'b0;
            end
            else if (busStart)
            begin
                state_q    <= chg_pkg::ST_ADDR;
                bitCnt_q   <= 4'h0;
                ackPhase_q <= 1'b0;
                sdaOe      <= 1'b0;
            end
            else if (sclRise && !ackPhase_q && state_q != chg_pkg::ST_IDLE)
            begin
                shift_q  <= {shift_q[6:0], sdaS};
                bitCnt_q <= bitCnt_q + 4'h1;
            end
            else if (sclRise && ackPhase_q && state_q == chg_pkg::ST_RDATA)
                masterNack_q <= sdaS;
            else if (sclFall && ackPhase_q)
            begin
                ackPhase_q <= 1'b0;
                sdaOe      <= 1'b0;
                if (state_q == chg_pkg::ST_RDATA)
                begin
                    if (masterNack_q)
                        state_q <= chg_pkg::ST_IDLE;
                    else
                        sdaOe <= ~txByte_q[7];
                end
            end
            else if (sclFall && state_q == chg_pkg::ST_RDATA && bitCnt_q != 4'h0
                     && bitCnt_q < 4'h8)
                sdaOe <= ~txByte_q[3'd7 - bitCnt_q[2:0]];
            else if (sclFall && bitCnt_q == 4'h8)
            begin
                bitCnt_q   <= 4'h0;
                ackPhase_q <= 1'b1;
                case (state_q)
                    chg_pkg::ST_ADDR:
                    begin
                        if (shift_q[7:1] == SLAVE_ADDR)
                        begin
                            sdaOe        <= 1'b1;
                            masterNack_q <= 1'b0;
                            if (shift_q[0])
                            begin
                                state_q  <= chg_pkg::ST_RDATA;
                                txByte_q <= regRead(ptr_q);
                                ptr_q    <= ptr_q + 8'h01;
                            end
                            else
                                state_q <= chg_pkg::ST_REG;
                        end
                        else
                        begin
                            state_q    <= chg_pkg::ST_IDLE;
                            ackPhase_q <= 1'b0;
                        end
                    end
                    chg_pkg::ST_REG:
                    begin
                        // unknown register: no acknowledge, back to idle
                        if (regValid(shift_q))
                        begin
                            sdaOe   <= 1'b1;
                            ptr_q   <= shift_q;
                            state_q <= chg_pkg::ST_WDATA;
                        end
                        else
                        begin
                            state_q    <= chg_pkg::ST_IDLE;
                            ackPhase_q <= 1'b0;
                        end
                    end
                    chg_pkg::ST_WDATA:
                    begin
                        if (regValid(ptr_q))
                        begin
                            sdaOe    <= 1'b1;
                            wrStb_q  <= 1'b1;
                            wrAddr_q <= ptr_q;
                            wrData_q <= shift_q;
                            ptr_q    <= ptr_q + 8'h01;
                        end
                        else
                        begin
                            state_q    <= chg_pkg::ST_IDLE;
                            ackPhase_q <= 1'b0;
                        end
                    end
                    chg_pkg::ST_RDATA:
                    begin
                        sdaOe    <= 1'b0;
                        txByte_q <= regRead(ptr_q);
                        ptr_q    <= ptr_q + 8'h01;
                    end
                    default:
                    begin
                        state_q    <= chg_pkg::ST_IDLE;
                        ackPhase_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // the watchdog is kicked by any accepted data byte
    assign hostWrite = wrStb_q;

    // ---------------------------------------------------------------
    // charge current control register
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            curr_q <= chg_pkg::CURR_RST;
        else if (regResetReq)
            curr_q <= chg_pkg::CURR_RST;
        else if (wrStb_q && wrAddr_q == chg_pkg::CURR_OFF)
            curr_q <= wrData_q;
        else if (watchdogExpired)
            curr_q <= chg_pkg::CURR_RST;
    end

    // ---------------------------------------------------------------
    // input voltage control register
    // ---------------------------------------------------------------
    // a host write in the expiry cycle is kept; the write restarts host mode
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            volt_q <= chg_pkg::VOLT_RST;
        else if (regResetReq)
            volt_q <= chg_pkg::VOLT_RST;
        else if (wrStb_q && wrAddr_q == chg_pkg::VOLT_OFF)
            volt_q <= wrData_q;
        else if (watchdogExpired)
            volt_q <= (volt_q & chg_pkg::VOLT_WD_KEEP)
                    | (chg_pkg::VOLT_RST & ~chg_pkg::VOLT_WD_KEEP);
        else if (sourceDetectDone && volt_q[chg_pkg::RESTORE_BIT])
            volt_q[chg_pkg::VLIM_MSB:0] <= chg_pkg::VLIM_RST;
    end

    // ---------------------------------------------------------------
    // settings driven to the power stage
    // ---------------------------------------------------------------
    chg_clamp #(
        .W  (6),
        .LO (chg_pkg::FCC_MIN),
        .HI (chg_pkg::FCC_MAX)
    ) u_clamp_fcc (
        .codeIn  (curr_q[chg_pkg::FCC_MSB:0]),
        .codeOut (fccClamped)
    );

    chg_clamp #(
        .W  (5),
        .LO (chg_pkg::VLIM_MIN),
        .HI (chg_pkg::VLIM_MAX)
    ) u_clamp_vlim (
        .codeIn  (volt_q[chg_pkg::VLIM_MSB:0]),
        .codeOut (vlimClamped)
    );

    // registered so the analog side never sees a clamp glitch
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            inputHighzEnable           <= chg_pkg::CURR_RST[chg_pkg::HIZ_BIT];
            limitPinEnable             <= chg_pkg::CURR_RST[chg_pkg::LIMPIN_BIT];
            fastChargeCurrentCode      <= chg_pkg::CURR_RST[chg_pkg::FCC_MSB:0];
            inputVlimitPluginRestore   <= chg_pkg::VOLT_RST[chg_pkg::RESTORE_BIT];
            batteryDischargeLoadEnable <= chg_pkg::VOLT_RST[chg_pkg::DISCH_BIT];
            outOfAudioDisable          <= chg_pkg::VOLT_RST[chg_pkg::OOA_BIT];
            inputVoltageLimitCode      <= chg_pkg::VLIM_RST;
        end
        else
        begin
            inputHighzEnable           <= curr_q[chg_pkg::HIZ_BIT];
            limitPinEnable             <= curr_q[chg_pkg::LIMPIN_BIT];
            fastChargeCurrentCode      <= fccClamped;
            inputVlimitPluginRestore   <= volt_q[chg_pkg::RESTORE_BIT];
            batteryDischargeLoadEnable <= volt_q[chg_pkg::DISCH_BIT];
            outOfAudioDisable          <= volt_q[chg_pkg::OOA_BIT];
            inputVoltageLimitCode      <= vlimClamped;
        end
    end
endmodule // chg_regs

/* include/chg_pkg.sv */
// constants for the charge current / input voltage control register pair
// assumes a serial-bus slave and watchdog/detection logic on the same clock
// Notes on behaviour
// - current register at 0x01 resets to 0x5e
// - current bit 6 enables external limit pin
// - current bits 5:0 are fast-charge code
// - charge code clamped to 0x01..0x2c
// - voltage register at 0x02 resets to 0x84
// - bit 7 restores voltage code after detection
// - voltage bit 6 connects battery discharge load
// - voltage bit 5 disables out-of-audio, watchdog-kept
// - voltage bits 4:0 limit code, watchdog-kept
// - voltage code above 0x10 clamped to 0x10
// - watchdog expiry resets non-preserved fields to defaults
package chg_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR   = 7'h6b;
    localparam logic [7:0] CURR_OFF     = 8'h01;
    localparam logic [7:0] VOLT_OFF     = 8'h02;
    localparam logic [7:0] CURR_RST     = 8'h5e;
    localparam logic [7:0] VOLT_RST     = 8'h84;
    // bits of the voltage register that survive a watchdog expiry
    localparam logic [7:0] VOLT_WD_KEEP = 8'h3f;

    // ---------------------------------------------------------------
    // field layout
    // ---------------------------------------------------------------
    localparam int HIZ_BIT      = 7;
    localparam int LIMPIN_BIT   = 6;
    localparam int FCC_MSB      = 5;
    localparam int RESTORE_BIT  = 7;
    localparam int DISCH_BIT    = 6;
    localparam int OOA_BIT      = 5;
    localparam int VLIM_MSB     = 4;

    // ---------------------------------------------------------------
    // code limits and defaults
    // ---------------------------------------------------------------
    localparam logic [5:0] FCC_MIN  = 6'h01;
    localparam logic [5:0] FCC_MAX  = 6'h2c;
    localparam logic [4:0] VLIM_MIN = 5'h00;
    localparam logic [4:0] VLIM_MAX = 5'h10;
    localparam logic [4:0] VLIM_RST = 5'h04;

    // ---------------------------------------------------------------
    // serial slave states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_RDATA
    } chg_bus_state_t;

endpackage

/* rtl/chg_sync.sv */
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module chg_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic pinIn,
    output logic      pinOut
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q   <= RST_VAL;
            s2_q   <= RST_VAL;
            s3_q   <= RST_VAL;
            pinOut <= RST_VAL;
        end
        else
        begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change counts only once stages two and three agree
            if (s2_q == s3_q)
                pinOut <= s3_q;
        end
    end
endmodule // chg_sync

/* rtl/chg_clamp.sv */
// clamps a code into [LO, HI]
// assumes unsigned codes
`timescale 1ns/1ps
module chg_clamp #(
    parameter int         W  = 6,
    parameter logic [W-1:0] LO = '0,
    parameter logic [W-1:0] HI = '1
) (
    input  wire logic [W-1:0] codeIn,
    output logic      [W-1:0] codeOut
);
    always_comb
    begin
        if (codeIn > HI)
            codeOut = HI;
        else if (codeIn < LO)
            codeOut = LO;
        else
            codeOut = codeIn;
    end
endmodule // chg_clamp

/* verification/chg_regs_assertions.sv */
// checker for the charge current / input voltage control outputs
// assumes one sys_clk domain; bound onto chg_regs below
`timescale 1ns/1ps
module chg_regs_assertions (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       regResetReq,
    input wire logic       watchdogExpired,
    input wire logic       sourceDetectDone,
    input wire logic       hostWrite,
    input wire logic       sdaOe,
    input wire logic       inputHighzEnable,
    input wire logic       limitPinEnable,
    input wire logic [5:0] fastChargeCurrentCode,
    input wire logic       inputVlimitPluginRestore,
    input wire logic       batteryDischargeLoadEnable,
    input wire logic       outOfAudioDisable,
    input wire logic [4:0] inputVoltageLimitCode
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // fields that both kinds of reset bring back
    wire logic comDef = !inputHighzEnable && limitPinEnable && fastChargeCurrentCode == 6'h1e
        && inputVlimitPluginRestore && !batteryDischargeLoadEnable;

    a_reset_defaults: assert property (regResetReq |-> ##2 comDef
        && !outOfAudioDisable && inputVoltageLimitCode == 5'h04)
        else $error("register reset did not restore defaults");
    a_fast_charge_current_code_clamped: assert property (fastChargeCurrentCode >= 6'h01
        && fastChargeCurrentCode <= 6'h2c)
        else $error("charge code outside clamp range");
    a_vlim_clamped: assert property (inputVoltageLimitCode <= 5'h10)
        else $error("voltage code above clamp");
    a_wd_defaults: assert property (watchdogExpired && !regResetReq && !hostWrite
        |-> ##2 comDef)
        else $error("watchdog expiry left a field unchanged");
    a_wd_keeps: assert property (watchdogExpired && !regResetReq && !hostWrite
        |-> ##2 $stable(outOfAudioDisable) && $stable(inputVoltageLimitCode))
        else $error("watchdog expiry changed a preserved field");
    a_restore_code: assert property (sourceDetectDone && inputVlimitPluginRestore
        && !hostWrite && !regResetReq && !watchdogExpired ##1 !hostWrite
        |-> ##1 inputVoltageLimitCode == 5'h04)
        else $error("voltage code not restored after detection");
    a_restore_off: assert property (sourceDetectDone && !inputVlimitPluginRestore
        && !hostWrite && !regResetReq && !watchdogExpired ##1 !hostWrite
        |-> ##1 $stable(inputVoltageLimitCode))
        else $error("voltage code changed with restore disabled");
    a_write_pulse: assert property (hostWrite |=> !hostWrite)
        else $error("write pulse longer than one cycle");
    a_ack_hold: assert property ($rose(sdaOe) |-> sdaOe[*8])
        else $error("data line drive dropped early");
endmodule // chg_regs_assertions

bind chg_regs chg_regs_assertions chk_u (.sys_clk, .nrst, .regResetReq, .watchdogExpired,
    .sourceDetectDone, .hostWrite, .sdaOe, .inputHighzEnable, .limitPinEnable,
    .fastChargeCurrentCode, .inputVlimitPluginRestore, .batteryDischargeLoadEnable,
    .outOfAudioDisable, .inputVoltageLimitCode);

/* verification/chg_host_model.sv */
// host controller on the two-wire bus: start, stop and 9-bit slots
// assumes sdaLine is the resolved open-drain level; device never stretches
`timescale 1ns/1ps
module chg_host_model (
    input  wire logic sys_clk,
    input  wire logic sdaLine,
    output logic      sclPin,
    output logic      sdaLowOe
);
    // ----------------------------------------------------------------
    // bus phases, 8 clocks per half bit to clear the input filter
    // ----------------------------------------------------------------
    initial
    begin
        sclPin   = 1'b1;
        sdaLowOe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic busStart();
        sdaLowOe <= 1'b0;
        hold(4);
        sclPin   <= 1'b1;
        hold(8);
        sdaLowOe <= 1'b1;
        hold(8);
        sclPin   <= 1'b0;
        hold(4);
    endtask
    task automatic busStop();
        sdaLowOe <= 1'b1;
        hold(4);
        sclPin   <= 1'b1;
        hold(8);
        sdaLowOe <= 1'b0;
        hold(8);
    endtask
    // msb first; a 1 releases the line so the device may answer
    task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sdaLowOe <= !tx[i];
            hold(4);
            sclPin   <= 1'b1;
            hold(4);
            rx[i] = sdaLine;
            hold(4);
            sclPin   <= 1'b0;
            hold(4);
        end
    endtask
endmodule // chg_host_model

/* verification/tb.sv */
// self-checking bench for the control register pair
// assumes chg_pkg compiled first; host model drives the serial pins
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    localparam logic [7:0] AW = {chg_pkg::SLAVE_ADDR, 1'b0};
    logic       sys_clk, nrst, regResetReq, watchdogExpired, sourceDetectDone;
    logic       sclPin, sdaLowOe, sdaOe, hostWrite, inputHighzEnable, limitPinEnable;
    logic       sdaOut;
    logic       inputVlimitPluginRestore, batteryDischargeLoadEnable, outOfAudioDisable;
    logic [5:0] fastChargeCurrentCode;
    logic [4:0] inputVoltageLimitCode;
    logic [8:0] rx;
    int         n_errors = 0, samples_checked = 0, nWrites = 0;
    // a device that drove a high level instead of pulling low would break every ack
    wire logic  sdaLine = !((sdaOe && !sdaOut) || sdaLowOe);
    logic [7:0] cur [7] = '{8'h80, 8'h00, 8'h2d, 8'h3f, 8'h6c, 8'h41, 8'h5e};
    logic [7:0] vol [4] = '{8'h51, 8'h3f, 8'h50, 8'h6a};

    chg_regs dut_u (.sys_clk(sys_clk), .nrst(nrst), .sclIn(sclPin), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .regResetReq(regResetReq),
        .watchdogExpired(watchdogExpired), .sourceDetectDone(sourceDetectDone),
        .hostWrite(hostWrite), .inputHighzEnable(inputHighzEnable),
        .limitPinEnable(limitPinEnable), .fastChargeCurrentCode(fastChargeCurrentCode),
        .inputVlimitPluginRestore(inputVlimitPluginRestore),
        .batteryDischargeLoadEnable(batteryDischargeLoadEnable),
        .outOfAudioDisable(outOfAudioDisable), .inputVoltageLimitCode(inputVoltageLimitCode));
    chg_host_model host_u (.sys_clk(sys_clk), .sdaLine(sdaLine), .sclPin(sclPin),
        .sdaLowOe(sdaLowOe));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // counted on the falling edge to stay clear of the launching edge
    always @(negedge sys_clk)
        if (hostWrite === 1'b1)
            nWrites++;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [5:0] clampI(input logic [5:0] x);
        return (x > 6'h2c) ? 6'h2c : ((x < 6'h01) ? 6'h01 : x);
    endfunction
    task automatic outs(input logic [7:0] c, input logic [7:0] v);
        chk("current outputs", {c[7:6], clampI(c[5:0])},
            {inputHighzEnable, limitPinEnable, fastChargeCurrentCode});
        chk("voltage outputs", {v[7:5], ((v[4:0] > 5'h10) ? 5'h10 : v[4:0])},
            {inputVlimitPluginRestore, batteryDischargeLoadEnable, outOfAudioDisable,
             inputVoltageLimitCode});
    endtask
    task automatic put(input logic [7:0] b, input logic expAck);
        host_u.xbyte({b, 1'b1}, rx);
        chk("ack", {7'h00, expAck}, {7'h00, !rx[0]});
    endtask
    task automatic regWrite(input logic [7:0] ra, input logic [7:0] d);
        int w0;
        w0 = nWrites;
        host_u.busStart();
        put(AW, 1'b1);
        put(ra, 1'b1);
        put(d, 1'b1);
        host_u.busStop();
        chk("write pulses", 8'(w0 + 1), 8'(nWrites));
    endtask
    // read of n bytes from ra, master nacks the last one
    task automatic regRead(input logic [7:0] ra, input logic [7:0] e0, input logic [7:0] e1,
                           input logic [7:0] e2, input int n);
        logic [7:0] e [3];
        e = '{e0, e1, e2};
        host_u.busStart();
        put(AW, 1'b1);
        put(ra, 1'b1);
        host_u.busStart();
        put(AW | 8'h01, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            host_u.xbyte({8'hff, i == n - 1}, rx);
            chk("read data", e[i], rx[8:1]);
        end
        host_u.busStop();
    endtask
    task automatic pulse(input int which);
        @(posedge sys_clk);
        case (which)
            0: regResetReq <= 1'b1;
            1: watchdogExpired <= 1'b1;
            default: sourceDetectDone <= 1'b1;
        endcase
        @(posedge sys_clk);
        {regResetReq, watchdogExpired, sourceDetectDone} <= 3'b000;
        repeat (3) @(posedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
    initial
    begin
        {regResetReq, watchdogExpired, sourceDetectDone} = 3'b000;
        nrst = 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        outs(8'h5e, 8'h84);
        regRead(8'h01, 8'h5e, 8'h84, 8'h00, 3);
        foreach (cur[i])
        begin
            regWrite(8'h01, cur[i]);
            outs(cur[i], 8'h84);
            regRead(8'h01, cur[i], 8'h00, 8'h00, 1);
        end
        foreach (vol[i])
        begin
            regWrite(8'h02, vol[i]);
            outs(8'h5e, vol[i]);
        end
        pulse(2);
        outs(8'h5e, 8'h6a);
        regWrite(8'h01, 8'h95);
        pulse(1);
        outs(8'h5e, 8'haa);
        regRead(8'h02, 8'haa, 8'h00, 8'h00, 1);
        pulse(2);
        outs(8'h5e, 8'ha4);
        pulse(0);
        outs(8'h5e, 8'h84);
        // auto-increment write, third byte runs off the end
        host_u.busStart();
        put(AW, 1'b1);
        put(8'h01, 1'b1);
        put(8'hc3, 1'b1);
        put(8'h1f, 1'b1);
        put(8'h77, 1'b0);
        host_u.busStop();
        outs(8'hc3, 8'h1f);
        // unmapped register, then a foreign slave address
        host_u.busStart();
        put(AW, 1'b1);
        put(8'h05, 1'b0);
        host_u.busStop();
        host_u.busStart();
        put(AW ^ 8'h20, 1'b0);
        host_u.busStop();
        regRead(8'h01, 8'hc3, 8'h1f, 8'h00, 3);
        end_sim();
    end
endmodule // tb
